// File: core/usb_port_params.svh
`ifndef USB_PORT_PARAMS_SVH
`define USB_PORT_PARAMS_SVH

// ----------------------------------------
// clock
// ----------------------------------------
`define CLK_MHZ 100

// ----------------------------------------
// times in their own units, then cycles
// ----------------------------------------
`define OC_QUAL_US 1700
`define OC_QUAL_CYC (`OC_QUAL_US * `CLK_MHZ)
`define HIC_ON_MS 2
`define HIC_ON_CYC (`HIC_ON_MS * 1000 * `CLK_MHZ)
`define HIC_OFF_S 2
`define HIC_OFF_CYC (`HIC_OFF_S * 1000000 * `CLK_MHZ)
`define SC_OFF_US 80
`define SC_OFF_CYC (`SC_OFF_US * `CLK_MHZ)
`define DETACH_DIS_MS 30
`define DETACH_DIS_CYC (`DETACH_DIS_MS * 1000 * `CLK_MHZ)
`define FLT_DG_MS 2
`define FLT_DG_CYC (`FLT_DG_MS * 1000 * `CLK_MHZ)
`define TEMP_REC_S 16
`define TEMP_REC_CYC (`TEMP_REC_S * 1000000 * `CLK_MHZ)
`define START_DLY_US 100
`define START_DLY_CYC (`START_DLY_US * `CLK_MHZ)

// ----------------------------------------
// register map
// ----------------------------------------
`define CTRL_OFFS 12'h000
`define STATUS_OFFS 12'h004
`define CTRL_RESET 32'h0000_0001
`define CTRL_PORT_EN_BIT 0
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// File: core/usb_port_pkg.sv
package usb_port_pkg;

	// configuration line class seen by the comparators
	typedef enum logic [1:0] {
		CC_OPEN = 2'h0,
		CC_RD = 2'h1,
		CC_RA = 2'h2
	} cc_class_t;

	// comparator and pin results
	typedef struct packed {
		logic oc;
		logic short_hit;
		logic in_ov;
		logic uvlo_ok;
		logic dline_ov;
		logic cc_ov;
		logic temp_hot;
		logic temp_cool;
		logic temp_tsd;
		logic vout_good;
		logic dp_06;
		logic legacy_strap;
		logic flt_pin;
		cc_class_t cc1;
		cc_class_t cc2;
	} cmp_t;

	typedef enum logic [4:0] {
		OC_NORMAL = 5'h01,
		OC_QUAL = 5'h02,
		OC_HIC_OFF = 5'h04,
		OC_HIC_ON = 5'h08,
		OC_SC_OFF = 5'h10
	} oc_state_t;

	typedef enum logic [1:0] {
		CC_UNATT = 2'h1,
		CC_ATT = 2'h2
	} cc_state_t;

endpackage

// File: core/sync2.sv
`timescale 1ns/1ps
`default_nettype none

module sync2 #(
	parameter int W = 1
) (
	// clock
	input wire logic clk,
	input wire logic rst,
	// data
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);

	logic [W-1:0] meta_reg;

	always_ff @(posedge clk) begin
		if (rst) begin
			meta_reg <= '0;
			q <= '0;
		end else begin
			meta_reg <= d;
			q <= meta_reg;
		end
	end

endmodule

`default_nettype wire

// File: core/usb_port_protect.sv
`timescale 1ns/1ps
`default_nettype none
`include "usb_port_params.svh"

module usb_port_protect #(
	parameter int unsigned QUAL_CYC = `OC_QUAL_CYC,
	parameter int unsigned HIC_ON_CYC = `HIC_ON_CYC,
	parameter int unsigned HIC_OFF_CYC = `HIC_OFF_CYC,
	parameter int unsigned SC_OFF_CYC = `SC_OFF_CYC,
	parameter int unsigned DIS_CYC = `DETACH_DIS_CYC,
	parameter int unsigned DG_CYC = `FLT_DG_CYC,
	parameter int unsigned REC_CYC = `TEMP_REC_CYC,
	parameter int unsigned START_CYC = `START_DLY_CYC
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// comparator results, asynchronous
	input wire usb_port_pkg::cmp_t cmp_raw,
	// power path
	output logic switch_on,
	output logic in_discharge,
	output logic out_discharge,
	output logic vbus_on,
	// data lines
	output logic data_sw_on,
	output logic dm_drive_06,
	// configuration lines
	output logic cc1_rp_en,
	output logic cc2_rp_en,
	output logic rp_low_cap,
	output logic vconn_cc1,
	output logic vconn_cc2,
	// open-drain fault pin
	output logic fault_out_n_out,
	output logic fault_out_n_oe,
	// axi4-lite write
	input wire logic [11:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read
	input wire logic [11:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);

	usb_port_pkg::cmp_t cmp;
	usb_port_pkg::oc_state_t oc_state_reg;
	usb_port_pkg::cc_state_t cc_state_reg;
	logic [31:0] oc_cnt_reg, start_cnt_reg, dis_cnt_reg, dg_cnt_reg, rec_cnt_reg;
	logic [31:0] ctrl_reg;
	logic init_reg, legacy_reg, start_done_reg, dis_active_reg, detach_reg;
	logic low_cap_reg, flt_reg, data_sw_reg, dm_drive_reg, vconn1_reg, vconn2_reg;
	logic port_en, sink_seen, accessory, oc_cond, flt_imm;

	// ----------------------------------------
	// input synchronisers
	// ----------------------------------------
	sync2 #(.W($bits(usb_port_pkg::cmp_t))) u_sync (
		.clk(clk),
		.rst(rst),
		.d(cmp_raw),
		.q(cmp)
	);

	// ----------------------------------------
	// legacy strap and start-up delay
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			init_reg <= 1'b0;
			legacy_reg <= 1'b0;
		end else if (!init_reg && cmp.uvlo_ok) begin
			init_reg <= 1'b1;
			legacy_reg <= cmp.legacy_strap;
		end
	end

	always_ff @(posedge clk) begin
		if (rst || !cmp.uvlo_ok) begin
			start_cnt_reg <= '0;
			start_done_reg <= 1'b0;
		end else if (!start_done_reg) begin
			start_cnt_reg <= start_cnt_reg + 32'h1;
			if (start_cnt_reg == START_CYC - 1)
				start_done_reg <= 1'b1;
		end
	end

	// ----------------------------------------
	// configuration line attach
	// ----------------------------------------
	assign sink_seen = (cmp.cc1 == usb_port_pkg::CC_RD) || (cmp.cc2 == usb_port_pkg::CC_RD);
	assign accessory = (cmp.cc1 == cmp.cc2) && (cmp.cc1 != usb_port_pkg::CC_OPEN);

	always_ff @(posedge clk) begin
		if (rst) begin
			cc_state_reg <= usb_port_pkg::CC_UNATT;
			detach_reg <= 1'b0;
			vconn1_reg <= 1'b0;
			vconn2_reg <= 1'b0;
		end else begin
			detach_reg <= 1'b0;
			case (cc_state_reg)
			usb_port_pkg::CC_UNATT: begin
				if (!legacy_reg && init_reg && sink_seen && !accessory) begin
					cc_state_reg <= usb_port_pkg::CC_ATT;
					vconn1_reg <= (cmp.cc1 == usb_port_pkg::CC_RA);
					vconn2_reg <= (cmp.cc2 == usb_port_pkg::CC_RA);
				end
			end
			usb_port_pkg::CC_ATT: begin
				if (!sink_seen || accessory || legacy_reg) begin
					cc_state_reg <= usb_port_pkg::CC_UNATT;
					detach_reg <= 1'b1;
					vconn1_reg <= 1'b0;
					vconn2_reg <= 1'b0;
				end
			end
			default: cc_state_reg <= usb_port_pkg::CC_UNATT;
			endcase
		end
	end

	assign vbus_on = legacy_reg || (cc_state_reg == usb_port_pkg::CC_ATT);
	assign vconn_cc1 = vconn1_reg;
	assign vconn_cc2 = vconn2_reg;
	assign cc1_rp_en = 1'b1;
	assign cc2_rp_en = 1'b1;

	// ----------------------------------------
	// detach discharge
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			dis_cnt_reg <= '0;
			dis_active_reg <= 1'b0;
		end else if (detach_reg) begin
			dis_cnt_reg <= '0;
			dis_active_reg <= 1'b1;
		end else if (dis_active_reg) begin
			dis_cnt_reg <= dis_cnt_reg + 32'h1;
			if (dis_cnt_reg == DIS_CYC - 1)
				dis_active_reg <= 1'b0;
		end
	end

	assign in_discharge = cmp.in_ov || dis_active_reg;
	assign out_discharge = dis_active_reg;

	// ----------------------------------------
	// temperature load shedding
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			low_cap_reg <= 1'b0;
			rec_cnt_reg <= '0;
		end else if (cmp.temp_hot) begin
			low_cap_reg <= 1'b1;
			rec_cnt_reg <= '0;
		end else if (low_cap_reg && cmp.temp_cool) begin
			rec_cnt_reg <= rec_cnt_reg + 32'h1;
			if (rec_cnt_reg == REC_CYC - 1)
				low_cap_reg <= 1'b0;
		end else begin
			rec_cnt_reg <= '0;
		end
	end

	assign rp_low_cap = low_cap_reg;

	// ----------------------------------------
	// over-current and short handling
	// ----------------------------------------
	assign port_en = vbus_on && start_done_reg && ctrl_reg[`CTRL_PORT_EN_BIT] && !cmp.temp_tsd;

	always_ff @(posedge clk) begin
		if (rst || !port_en) begin
			oc_state_reg <= usb_port_pkg::OC_NORMAL;
			oc_cnt_reg <= '0;
		end else begin
			oc_cnt_reg <= oc_cnt_reg + 32'h1;
			case (oc_state_reg)
			usb_port_pkg::OC_NORMAL: begin
				oc_cnt_reg <= '0;
				if (cmp.short_hit)
					oc_state_reg <= usb_port_pkg::OC_SC_OFF;
				else if (cmp.oc)
					oc_state_reg <= usb_port_pkg::OC_QUAL;
			end
			usb_port_pkg::OC_QUAL: begin
				if (cmp.short_hit) begin
					oc_state_reg <= usb_port_pkg::OC_SC_OFF;
					oc_cnt_reg <= '0;
				end else if (!cmp.oc) begin
					oc_state_reg <= usb_port_pkg::OC_NORMAL;
					oc_cnt_reg <= '0;
				end else if (oc_cnt_reg == QUAL_CYC - 1) begin
					oc_state_reg <= usb_port_pkg::OC_HIC_OFF;
					oc_cnt_reg <= '0;
				end
			end
			usb_port_pkg::OC_HIC_OFF: begin
				if (oc_cnt_reg == HIC_OFF_CYC - 1) begin
					oc_state_reg <= usb_port_pkg::OC_HIC_ON;
					oc_cnt_reg <= '0;
				end
			end
			usb_port_pkg::OC_HIC_ON: begin
				if (cmp.short_hit) begin
					oc_state_reg <= usb_port_pkg::OC_HIC_OFF;
					oc_cnt_reg <= '0;
				end else if (oc_cnt_reg == HIC_ON_CYC - 1) begin
					oc_cnt_reg <= '0;
					if (cmp.oc)
						oc_state_reg <= usb_port_pkg::OC_HIC_OFF;
					else
						oc_state_reg <= usb_port_pkg::OC_NORMAL;
				end
			end
			usb_port_pkg::OC_SC_OFF: begin
				if (oc_cnt_reg == SC_OFF_CYC - 1) begin
					oc_state_reg <= usb_port_pkg::OC_HIC_ON;
					oc_cnt_reg <= '0;
				end
			end
			default: oc_state_reg <= usb_port_pkg::OC_NORMAL;
			endcase
		end
	end

	// fast path: a short cuts the switch before the state moves
	assign switch_on = port_en && !cmp.short_hit &&
		(oc_state_reg == usb_port_pkg::OC_NORMAL || oc_state_reg == usb_port_pkg::OC_QUAL ||
		oc_state_reg == usb_port_pkg::OC_HIC_ON);

	// ----------------------------------------
	// data lines
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			data_sw_reg <= 1'b0;
			dm_drive_reg <= 1'b0;
		end else begin
			data_sw_reg <= !cmp.dline_ov;
			dm_drive_reg <= cmp.dp_06;
		end
	end

	assign data_sw_on = data_sw_reg;
	assign dm_drive_06 = dm_drive_reg;

	// ----------------------------------------
	// fault pin
	// ----------------------------------------
	assign oc_cond = cmp.oc || cmp.short_hit || (oc_state_reg == usb_port_pkg::OC_HIC_OFF) ||
		(oc_state_reg == usb_port_pkg::OC_SC_OFF);
	assign flt_imm = cmp.in_ov || cmp.dline_ov || cmp.cc_ov || cmp.temp_tsd;

	always_ff @(posedge clk) begin
		if (rst || !oc_cond)
			dg_cnt_reg <= '0;
		else if (dg_cnt_reg != DG_CYC - 1)
			dg_cnt_reg <= dg_cnt_reg + 32'h1;
	end

	always_ff @(posedge clk) begin
		if (rst)
			flt_reg <= 1'b0;
		else if (flt_imm || (oc_cond && dg_cnt_reg == DG_CYC - 1))
			flt_reg <= 1'b1;
		else if (!oc_cond && cmp.vout_good)
			flt_reg <= 1'b0;
	end

	assign fault_out_n_out = 1'b0;
	assign fault_out_n_oe = flt_reg;

	// ----------------------------------------
	// axi4-lite slave
	// ----------------------------------------
	logic aw_full_reg, w_full_reg;
	logic [11:0] awaddr_reg;
	logic [31:0] wdata_reg;
	logic [3:0] wstrb_reg;

	assign s_axi_awready = !aw_full_reg;
	assign s_axi_wready = !w_full_reg;
	assign s_axi_arready = !s_axi_rvalid;

	always_ff @(posedge clk) begin
		if (rst) begin
			aw_full_reg <= 1'b0;
			w_full_reg <= 1'b0;
			awaddr_reg <= '0;
			wdata_reg <= '0;
			wstrb_reg <= '0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `RESP_OKAY;
			ctrl_reg <= `CTRL_RESET;
		end else begin
			if (s_axi_awvalid && !aw_full_reg) begin
				aw_full_reg <= 1'b1;
				awaddr_reg <= s_axi_awaddr;
			end
			if (s_axi_wvalid && !w_full_reg) begin
				w_full_reg <= 1'b1;
				wdata_reg <= s_axi_wdata;
				wstrb_reg <= s_axi_wstrb;
			end
			if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
			if (aw_full_reg && w_full_reg && !s_axi_bvalid) begin
				aw_full_reg <= 1'b0;
				w_full_reg <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= `RESP_SLVERR;
				if (awaddr_reg[11:2] == `CTRL_OFFS >> 2) begin
					s_axi_bresp <= `RESP_OKAY;
					for (int i = 0; i < 4; i++) begin
						if (wstrb_reg[i])
							ctrl_reg[8*i +: 8] <= wdata_reg[8*i +: 8];
					end
				end else if (awaddr_reg[11:2] == `STATUS_OFFS >> 2) begin
					s_axi_bresp <= `RESP_OKAY;
				end
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= `RESP_OKAY;
		end else if (s_axi_arvalid && !s_axi_rvalid) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= `RESP_OKAY;
			if (s_axi_araddr[11:2] == `CTRL_OFFS >> 2) begin
				s_axi_rdata <= ctrl_reg;
			end else if (s_axi_araddr[11:2] == `STATUS_OFFS >> 2) begin
				s_axi_rdata <= {16'h0, cmp.flt_pin, flt_reg, low_cap_reg, vconn2_reg,
					vconn1_reg, vbus_on, legacy_reg, start_done_reg, 3'h0, oc_state_reg};
			end else begin
				s_axi_rdata <= '0;
				s_axi_rresp <= `RESP_SLVERR;
			end
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	sequence s_detach;
		cc_state_reg == usb_port_pkg::CC_ATT ##1 cc_state_reg == usb_port_pkg::CC_UNATT;
	endsequence

	chk_qual_no_limit: assert property (
		oc_state_reg == usb_port_pkg::OC_QUAL && port_en && !cmp.short_hit |-> switch_on)
		else $error("switch limited during qualification");
	chk_qual_expiry: assert property (
		oc_state_reg == usb_port_pkg::OC_QUAL && oc_cnt_reg == QUAL_CYC - 1 && cmp.oc &&
		!cmp.short_hit && port_en |=> oc_state_reg == usb_port_pkg::OC_HIC_OFF && !switch_on)
		else $error("no hiccup after qualification");
	chk_qual_clear: assert property (
		oc_state_reg == usb_port_pkg::OC_QUAL && !cmp.oc && !cmp.short_hit && port_en
		|=> oc_state_reg == usb_port_pkg::OC_NORMAL && oc_cnt_reg == 32'h0)
		else $error("timer not cleared");
	chk_fast_off: assert property (
		cmp.short_hit && port_en && (oc_state_reg == usb_port_pkg::OC_NORMAL ||
		oc_state_reg == usb_port_pkg::OC_QUAL || oc_state_reg == usb_port_pkg::OC_HIC_ON)
		|-> !switch_on ##1 !switch_on)
		else $error("switch on during short");
	chk_sc_retry: assert property (
		oc_state_reg == usb_port_pkg::OC_SC_OFF && oc_cnt_reg == SC_OFF_CYC - 1 && port_en
		|=> oc_state_reg == usb_port_pkg::OC_HIC_ON)
		else $error("no retry after short off time");
	chk_detach_dis: assert property (
		s_detach |=> out_discharge && in_discharge)
		else $error("no discharge after detach");
	chk_data_cut: assert property (
		cmp.dline_ov |=> !data_sw_on)
		else $error("data switch closed over 4V");
	chk_accessory_off: assert property (
		accessory && init_reg && !legacy_reg |=> !vbus_on)
		else $error("vbus on with accessory");
	chk_flt_fast: assert property (
		flt_imm |=> fault_out_n_oe)
		else $error("fault pin not driven at once");

endmodule

`default_nettype wire

// File: test/usb_sink_model.sv
`timescale 1ns/1ps
`default_nettype none

module usb_sink_model #(
	parameter int RAMP = 3
) (
	// clock
	input wire logic clk,
	// what is plugged in, port power
	input wire logic [2:0] mode,
	input wire logic switch_on,
	// line classes and port voltage sense
	output logic [1:0] cc1,
	output logic [1:0] cc2,
	output logic vout_good
);
	// {cc1, cc2}: open, rd/-, -/rd, ra/rd, rd/ra, ra/ra, rd/rd, ra/-
	localparam logic [3:0] TERM [8] = '{4'h0, 4'h4, 4'h1, 4'h9, 4'h6, 4'ha, 4'h5, 4'h8};
	int ramp_cnt = 0;

	// ----------------------------------------
	// terminations
	// ----------------------------------------
	assign {cc1, cc2} = TERM[mode];

	// ----------------------------------------
	// port voltage ramps after switch on
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (!switch_on) begin
			ramp_cnt <= 0;
		end else if (ramp_cnt < RAMP) begin
			ramp_cnt <= ramp_cnt + 1;
		end
	end
	assign vout_good = (ramp_cnt == RAMP);
endmodule

`default_nettype wire

// File: test/tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "usb_port_params.svh"

module tb;
	logic clk = 1'h0;
	logic rst = 1'h1;
	usb_port_pkg::cmp_t cmp = '0;
	usb_port_pkg::cmp_t cmp_in;
	logic [2:0] mode = 3'h0;
	logic [1:0] cc1_w;
	logic [1:0] cc2_w;
	logic vout_good_w;
	logic switch_on, in_discharge, out_discharge, vbus_on, data_sw_on, dm_drive_06;
	logic cc1_rp_en, cc2_rp_en, rp_low_cap, vconn_cc1, vconn_cc2;
	logic fault_out_n_out, fault_out_n_oe;
	logic [11:0] s_axi_awaddr;
	logic [11:0] s_axi_araddr;
	logic [31:0] s_axi_wdata;
	logic [3:0] s_axi_wstrb;
	logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp;
	logic [1:0] s_axi_rresp;
	logic [31:0] s_axi_rdata;
	int miscompares = 0;
	int tests_run = 0;
	int seed = 97;

	always #5 clk = ~clk;

	// ----------------------------------------
	// comparator view: far side plus pulled-up fault pin
	// ----------------------------------------
	always_comb begin
		cmp_in = cmp;
		cmp_in.cc1 = usb_port_pkg::cc_class_t'(cc1_w);
		cmp_in.cc2 = usb_port_pkg::cc_class_t'(cc2_w);
		cmp_in.vout_good = vout_good_w;
		cmp_in.flt_pin = !fault_out_n_oe;
	end

	usb_sink_model #(.RAMP(3)) sink (.clk, .mode, .switch_on, .cc1(cc1_w), .cc2(cc2_w),
		.vout_good(vout_good_w));

	usb_port_protect #(.QUAL_CYC(20), .HIC_ON_CYC(10), .HIC_OFF_CYC(30), .SC_OFF_CYC(8),
		.DIS_CYC(15), .DG_CYC(12), .REC_CYC(25), .START_CYC(5)) dut (
		.clk, .rst, .cmp_raw(cmp_in), .switch_on, .in_discharge, .out_discharge, .vbus_on,
		.data_sw_on, .dm_drive_06, .cc1_rp_en, .cc2_rp_en, .rp_low_cap, .vconn_cc1,
		.vconn_cc2, .fault_out_n_out, .fault_out_n_oe, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic exp_vbus(input logic [2:0] m);
		return m inside {3'h1, 3'h2, 3'h3, 3'h4};
	endfunction

	function automatic logic [1:0] exp_vconn(input logic [2:0] m);
		return {m == 3'h4, m == 3'h3};
	endfunction

	task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
		tests_run++;
		if (got !== exp) begin
			miscompares++;
			$display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask

	task automatic axi_write(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_awvalid <= 1'h1;
		s_axi_wdata <= d;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		do begin
			@(posedge clk);
			if (s_axi_awvalid === 1'h1 && s_axi_awready === 1'h1) s_axi_awvalid <= 1'h0;
			if (s_axi_wvalid === 1'h1 && s_axi_wready === 1'h1) s_axi_wvalid <= 1'h0;
		end while (s_axi_bvalid !== 1'h1);
		r = s_axi_bresp;
		s_axi_bready <= 1'h0;
	endtask

	task automatic axi_read(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		do begin
			@(posedge clk);
			if (s_axi_arvalid === 1'h1 && s_axi_arready === 1'h1) s_axi_arvalid <= 1'h0;
		end while (s_axi_rvalid !== 1'h1);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'h0;
	endtask

	task automatic state_is(input logic [4:0] exp, input string what);
		logic [31:0] d;
		logic [1:0] r;
		axi_read(`STATUS_OFFS, d, r);
		check(d[4:0], exp, what);
	endtask

	task automatic done_test(input string name);
		$display("test %s done", name);
	endtask

	task automatic stop_test();
		$display("comparisons %0d, mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	initial begin
		#200000;
		miscompares++;
		$display("wrong value at %0t: watchdog expired", $time);
		stop_test();
	end

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		logic [31:0] rd;
		logic [1:0] resp;
		logic [2:0] m;
		logic [31:0] wd;
		s_axi_awaddr <= 12'h0;
		s_axi_araddr <= 12'h0;
		s_axi_wdata <= 32'h0;
		s_axi_wstrb <= 4'hf;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} <= 5'h0;
		cyc(6);
		check(switch_on, 1'h0, "switch in reset");
		check(fault_out_n_out, 1'h0, "fault pin pulls low only");
		check(vbus_on, 1'h0, "vbus in reset");
		check(fault_out_n_oe, 1'h0, "fault in reset");
		check({cc2_rp_en, cc1_rp_en}, 2'h3, "pull-ups");
		check(rp_low_cap, 1'h0, "default capability");
		rst <= 1'h0;
		cmp.uvlo_ok <= 1'h1;
		axi_read(`CTRL_OFFS, rd, resp);
		check(rd, `CTRL_RESET, "ctrl reset value");
		axi_read(12'h010, rd, resp);
		check(resp, `RESP_SLVERR, "unmapped read response");
		check(rd, 32'h0, "unmapped read data");
		axi_write(`STATUS_OFFS, 32'hffff_ffff, resp);
		check(resp, `RESP_OKAY, "status write response");
		axi_write(`CTRL_OFFS, 32'h0, resp);
		axi_read(`CTRL_OFFS, rd, resp);
		check(rd, 32'h0, "ctrl readback");
		axi_write(`CTRL_OFFS, 32'h1, resp);
		wd = $random(seed);
		s_axi_wstrb <= 4'h2;
		axi_write(`CTRL_OFFS, wd, resp);
		s_axi_wstrb <= 4'hf;
		axi_read(`CTRL_OFFS, rd, resp);
		check(rd, {16'h0, wd[15:8], 8'h01}, "byte strobe write");
		done_test("registers");
		mode <= 3'h3;
		cyc(20);
		check(vbus_on, 1'h1, "vbus after attach");
		check({vconn_cc2, vconn_cc1}, 2'h1, "vconn on cable line");
		check(switch_on, 1'h1, "switch after start");
		check(data_sw_on, 1'h1, "data switch closed");
		check(fault_out_n_oe, 1'h0, "fault released");
		cmp.dp_06 <= 1'h1;
		cyc(5);
		check(dm_drive_06, 1'h1, "dm follows dp");
		cmp.dp_06 <= 1'h0;
		cyc(5);
		check(dm_drive_06, 1'h0, "dm released");
		cmp.dline_ov <= 1'h1;
		cyc(4);
		check(data_sw_on, 1'h0, "data switch opened");
		check(fault_out_n_oe, 1'h1, "data line fault");
		cmp.dline_ov <= 1'h0;
		cmp.in_ov <= 1'h1;
		cyc(4);
		check(fault_out_n_oe, 1'h1, "input fault");
		check({in_discharge, switch_on}, 2'h3, "input discharge, switch kept");
		cmp.in_ov <= 1'h0;
		cyc(6);
		check({in_discharge, data_sw_on, fault_out_n_oe}, 3'h2, "faults cleared");
		cmp.cc_ov <= 1'h1;
		cyc(4);
		check(fault_out_n_oe, 1'h1, "config line fault");
		cmp.cc_ov <= 1'h0;
		cyc(6);
		check(fault_out_n_oe, 1'h0, "config line fault cleared");
		done_test("line faults");
		cmp.oc <= 1'h1;
		cyc(10);
		cmp.oc <= 1'h0;
		cyc(6);
		check({switch_on, fault_out_n_oe}, 2'h2, "short overcurrent ignored");
		state_is(5'h01, "qualification cleared");
		cmp.oc <= 1'h1;
		cyc(10);
		check(fault_out_n_oe, 1'h0, "fault within deglitch");
		cyc(6);
		check(fault_out_n_oe, 1'h1, "fault after deglitch");
		check(switch_on, 1'h1, "no limiting while qualifying");
		cyc(12);
		check(switch_on, 1'h0, "hiccup off");
		state_is(5'h04, "hiccup off state");
		cmp.oc <= 1'h0;
		cyc(5);
		check(fault_out_n_oe, 1'h1, "fault held while output low");
		cyc(30);
		check(switch_on, 1'h1, "hiccup retry");
		cyc(20);
		state_is(5'h01, "normal after hiccup");
		check(fault_out_n_oe, 1'h0, "fault released after recovery");
		done_test("overcurrent");
		cmp.short_hit <= 1'h1;
		cyc(3);
		check(switch_on, 1'h0, "fast off");
		cmp.short_hit <= 1'h0;
		cyc(3);
		state_is(5'h10, "short hold");
		cyc(8);
		check(switch_on, 1'h1, "on after hold");
		cyc(20);
		state_is(5'h01, "recovered");
		cmp.short_hit <= 1'h1;
		cyc(18);
		state_is(5'h04, "persisting short to hiccup");
		cmp.short_hit <= 1'h0;
		cyc(60);
		state_is(5'h01, "short removed");
		check(switch_on, 1'h1, "switch after short");
		done_test("short");
		cmp.temp_hot <= 1'h1;
		cyc(5);
		check(rp_low_cap, 1'h1, "hot reduces capability");
		cmp.temp_hot <= 1'h0;
		cmp.temp_cool <= 1'h1;
		cyc(15);
		check(rp_low_cap, 1'h1, "recovery not yet");
		cyc(25);
		check(rp_low_cap, 1'h0, "capability restored");
		cmp.temp_tsd <= 1'h1;
		cyc(4);
		check({switch_on, fault_out_n_oe}, 2'h1, "thermal fault");
		cmp.temp_tsd <= 1'h0;
		cyc(12);
		check(fault_out_n_oe, 1'h0, "thermal fault cleared");
		done_test("temperature");
		mode <= 3'h0;
		cyc(7);
		check({vbus_on, vconn_cc1}, 2'h0, "detach removes power");
		check({in_discharge, out_discharge}, 2'h3, "detach discharge");
		cyc(20);
		check({in_discharge, out_discharge}, 2'h0, "discharge ends");
		for (int i = 0; i < 16; i++) begin
			m = (i < 8) ? i[2:0] : 3'($random(seed));
			mode <= 3'h0;
			cyc(25);
			mode <= m;
			cyc(8);
			check(vbus_on, exp_vbus(m), "vbus for termination");
			check({vconn_cc2, vconn_cc1}, exp_vconn(m), "vconn for termination");
		end
		done_test("terminations");
		mode <= 3'h0;
		cmp.legacy_strap <= 1'h1;
		rst <= 1'h1;
		cyc(6);
		rst <= 1'h0;
		cyc(1);
		check({switch_on, vbus_on, fault_out_n_oe}, 3'h0, "outputs after second reset");
		cyc(9);
		check({switch_on, vbus_on}, 2'h3, "legacy strap powers port");
		mode <= 3'h3;
		cyc(8);
		check({vbus_on, vconn_cc2, vconn_cc1}, 3'h4, "legacy ignores attach");
		done_test("legacy");
		stop_test();
	end
endmodule

`default_nettype wire
